// [psa_pkg.sv]
// Purpose: constants, register map and state types of the phase sync / phase adjust block
// Assumes: one 10 MHz reference clock, Avalon-MM register access
// Notes:   all offsets are byte addresses of 32-bit words
`default_nettype none

package psa_pkg;

    localparam int          REF_CLK_HZ       = 10_000_000;
    localparam int          SETTLE_TIME_US   = 50;
    localparam logic [15:0] SETTLE_CYCLES    =
        16'((SETTLE_TIME_US * (REF_CLK_HZ / 1_000_000)));

    localparam logic [5:0]  OFS_CTRL         = 6'h00;
    localparam logic [5:0]  OFS_DIV          = 6'h04;
    localparam logic [5:0]  OFS_DEN          = 6'h08;
    localparam logic [5:0]  OFS_SEED         = 6'h0C;
    localparam logic [5:0]  OFS_RSTDLY       = 6'h10;
    localparam logic [5:0]  OFS_STATUS       = 6'h14;
    localparam logic [5:0]  OFS_PHASE        = 6'h18;
    localparam logic [5:0]  OFS_VCO_READ     = 6'h1C;
    localparam logic [5:0]  OFS_VCO_FORCE    = 6'h20;

    localparam int          CTRL_SYNC_EN     = 0;
    localparam int          CTRL_PIN_MASK    = 1;
    localparam int          CTRL_INIT        = 2;
    localparam int          CTRL_MOD_RST     = 3;
    localparam int          CTRL_FRAC        = 4;
    localparam int          CTRL_ORDER_LSB   = 5;
    localparam int          DIV_RATIO_LSB    = 0;
    localparam int          DIV_ASEL_LSB     = 8;
    localparam int          DIV_BSEL_LSB     = 10;
    localparam int          VCO_CORE_LSB     = 0;
    localparam int          VCO_CAP_LSB      = 3;
    localparam int          VCO_BIAS_LSB     = 11;
    localparam int          VCO_FORCE_BIT    = 31;

    localparam logic [1:0]  SEL_OUTPUT_DIVIDE_RATIO        = 2'h0;
    localparam logic [1:0]  SEL_VCO          = 2'h1;
    localparam logic [1:0]  SEL_CONV_REF     = 2'h2;

    localparam logic        RST_PIN_MASK     = 1'h1;
    localparam logic [7:0]  RST_RATIO        = 8'h02;
    localparam logic [1:0]  RST_SEL          = 2'h1;
    localparam logic [23:0] RST_DEN          = 24'h000001;
    localparam logic [15:0] RST_RSTDLY       = 16'h0000;
    localparam logic [39:0] FULL_TURN_DEG    = 40'h0000000168;

    typedef enum logic [2:0] {
        SEQ_IDLE   = 3'b000,
        SEQ_CAL    = 3'b001,
        SEQ_SETTLE = 3'b010,
        SEQ_MODRST = 3'b011,
        SEQ_DONE   = 3'b100
    } psa_seq_e;

    typedef enum logic [1:0] {
        CALC_IDLE  = 2'b00,
        CALC_MOD   = 2'b01,
        CALC_PHASE = 2'b10
    } psa_calc_e;

endpackage

`default_nettype wire

// [psa_incl_div.sv]
// Purpose: included feedback divide and second divider stage
// Assumes: selections and ratio come from registers on the same clock
// Notes:   purely combinational
`default_nettype none

module psa_incl_div
    import psa_pkg::*;
(
    input  wire logic       sync_en,
    input  wire logic [7:0] ratio,
    input  wire logic [1:0] a_sel,
    input  wire logic [1:0] b_sel,
    output logic      [2:0] incl,
    output logic      [1:0] stage_second
);
    logic uses_div;

    always_comb begin
        uses_div = (a_sel == SEL_OUTPUT_DIVIDE_RATIO) || (b_sel == SEL_OUTPUT_DIVIDE_RATIO) || (b_sel == SEL_CONV_REF);
        // three for ratios divisible by three, except 24 and 192 which give two
        if ((ratio % 8'h03) == 8'h00 && ratio != 8'h18 && ratio != 8'hC0 && ratio != 8'h02) begin
            stage_second = 2'h3;
        end else begin
            stage_second = 2'h2;
        end
        // unity without the divider in path
        if (!sync_en || !uses_div) begin
            incl = 3'h1;
        end else begin
            incl = {stage_second, 1'b0};
        end
    end
endmodule

`default_nettype wire

// [psa_divider.sv]
// Purpose: sequential restoring divider for phase arithmetic
// Assumes: start only while not busy
// Notes:   one bit per cycle; a zero divisor gives all ones
`default_nettype none

module psa_divider
    import psa_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        start,
    input  wire logic [39:0] dividend,
    input  wire logic [39:0] divisor,
    output logic             busy,
    output logic             done,
    output logic      [39:0] quotient,
    output logic      [39:0] remainder
);
    typedef struct packed {
        logic [39:0] rem;
        logic [39:0] quo;
        logic [39:0] dsr;
        logic [5:0]  cnt;
        logic        busy;
        logic        done;
    } psa_div_s;

    psa_div_s s;
    psa_div_s next_s;

    always_comb begin
        logic [40:0] trial;
        trial = 41'h0;
        next_s = s;
        next_s.done = 1'b0;
        if (start && !s.busy) begin
            next_s.rem = 40'h0;
            next_s.quo = dividend;
            next_s.dsr = divisor;
            next_s.cnt = 6'h28;
            next_s.busy = 1'b1;
        end else if (s.busy) begin
            trial = {s.rem, s.quo[39]};
            if (trial >= {1'b0, s.dsr}) begin
                next_s.rem = 40'(trial - {1'b0, s.dsr});
                next_s.quo = {s.quo[38:0], 1'b1};
            end else begin
                next_s.rem = trial[39:0];
                next_s.quo = {s.quo[38:0], 1'b0};
            end
            next_s.cnt = s.cnt - 6'h01;
            if (s.cnt == 6'h01) begin
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign busy      = s.busy;
    assign done      = s.done;
    assign quotient  = s.quo;
    assign remainder = s.rem;
endmodule

`default_nettype wire

// [psa_top.sv]
// Purpose: phase synchronisation and phase adjust control with Avalon-MM registers
// Assumes: calibration engine and modulator sit on REF_CLK; SYNC_PIN is asynchronous
// Notes:   every access takes one wait state
`default_nettype none

module psa_top
    import psa_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        RESET_N,
    input  wire logic [5:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic        SYNC_PIN,
    input  wire logic        CAL_DONE,
    input  wire logic [2:0]  CAL_CORE,
    input  wire logic [7:0]  CAL_CAPCODE,
    input  wire logic [8:0]  CAL_BIAS,
    output logic             SYNC_MODE,
    output logic             SYNC_PULSE,
    output logic             CAL_START,
    output logic             MOD_RESET,
    output logic             PHASE_DETERMINISTIC,
    output logic      [2:0]  INCLUDED_DIVIDE,
    output logic      [1:0]  STAGE_SECOND,
    output logic      [23:0] PHASE_OFFSET,
    output logic             FORCE_EN,
    output logic      [2:0]  FORCE_CORE,
    output logic      [7:0]  FORCE_CAPCODE,
    output logic      [8:0]  FORCE_BIAS
);
    typedef struct packed {
        logic        pin_meta;
        logic        pin_sync;
        logic        pin_last;
        logic        sync_en;
        logic        pin_mask;
        logic        frac_mode;
        logic [2:0]  order;
        logic [7:0]  ratio;
        logic [1:0]  a_sel;
        logic [1:0]  b_sel;
        logic [23:0] den;
        logic [23:0] acc;
        logic [15:0] rst_dly;
        logic        force_en;
        logic [2:0]  force_core;
        logic [7:0]  force_cap;
        logic [8:0]  force_bias;
        logic [2:0]  rd_core;
        logic [7:0]  rd_cap;
        logic [8:0]  rd_bias;
        logic        ack;
        logic [31:0] rdata;
        psa_seq_e    seq;
        logic [15:0] cnt;
        logic        determ;
        logic        sync_pulse;
        logic        cal_start;
        logic        mod_rst;
        logic [2:0]  incl;
        logic [1:0]  stage2;
        psa_calc_e   calc;
        logic        dirty;
        logic [31:0] phase;
        logic        shift_ok;
    } psa_state_s;

    psa_state_s  s;
    psa_state_s  next_s;
    logic [2:0]  incl_now;
    logic [1:0]  stage2_now;
    logic        div_start;
    logic [39:0] div_dividend;
    logic [39:0] div_divisor;
    logic        div_busy;
    logic        div_done;
    logic [39:0] div_quo;
    logic [39:0] div_rem;
    logic        wr_acc;
    logic        rd_acc;
    logic        sw_sync;
    logic        pin_event;
    logic        sync_event;
    logic        sw_mod_rst;
    logic        seed_wr;

    psa_incl_div u_incl (
        .sync_en      (s.sync_en),
        .ratio        (s.ratio),
        .a_sel        (s.a_sel),
        .b_sel        (s.b_sel),
        .incl         (incl_now),
        .stage_second (stage2_now)
    );

    psa_divider u_div (
        .clk       (REF_CLK),
        .reset_n   (RESET_N),
        .start     (div_start),
        .dividend  (div_dividend),
        .divisor   (div_divisor),
        .busy      (div_busy),
        .done      (div_done),
        .quotient  (div_quo),
        .remainder (div_rem)
    );

    always_comb begin
        next_s = s;
        // a request is taken on the edge where waitrequest is already low
        wr_acc = AVS_WRITE && s.ack;
        rd_acc = AVS_READ && s.ack;
        next_s.ack = (AVS_READ || AVS_WRITE) && !s.ack;
        next_s.pin_meta = SYNC_PIN;
        next_s.pin_sync = s.pin_meta;
        next_s.pin_last = s.pin_sync;
        sw_sync = wr_acc && AVS_ADDRESS == OFS_CTRL && AVS_WRITEDATA[CTRL_SYNC_EN]
                  && !s.sync_en && !AVS_WRITEDATA[CTRL_INIT];
        pin_event = s.sync_en && !s.pin_mask && s.pin_sync && !s.pin_last;
        sync_event = sw_sync || pin_event;
        sw_mod_rst = wr_acc && AVS_ADDRESS == OFS_CTRL && AVS_WRITEDATA[CTRL_MOD_RST];
        seed_wr = wr_acc && AVS_ADDRESS == OFS_SEED;
        next_s.incl = incl_now;
        next_s.stage2 = stage2_now;
        if (wr_acc) begin
            unique case (AVS_ADDRESS)
                OFS_CTRL: begin
                    next_s.sync_en = AVS_WRITEDATA[CTRL_SYNC_EN];
                    next_s.pin_mask = AVS_WRITEDATA[CTRL_PIN_MASK];
                    next_s.frac_mode = AVS_WRITEDATA[CTRL_FRAC];
                    next_s.order = AVS_WRITEDATA[CTRL_ORDER_LSB +: 3];
                end
                OFS_DIV: begin
                    next_s.ratio = AVS_WRITEDATA[DIV_RATIO_LSB +: 8];
                    next_s.a_sel = AVS_WRITEDATA[DIV_ASEL_LSB +: 2];
                    next_s.b_sel = AVS_WRITEDATA[DIV_BSEL_LSB +: 2];
                end
                OFS_DEN: next_s.den = AVS_WRITEDATA[23:0];
                OFS_RSTDLY: next_s.rst_dly = AVS_WRITEDATA[15:0];
                OFS_VCO_FORCE: begin
                    next_s.force_en = AVS_WRITEDATA[VCO_FORCE_BIT];
                    next_s.force_core = AVS_WRITEDATA[VCO_CORE_LSB +: 3];
                    next_s.force_cap = AVS_WRITEDATA[VCO_CAP_LSB +: 8];
                    next_s.force_bias = AVS_WRITEDATA[VCO_BIAS_LSB +: 9];
                end
                default: ;
            endcase
        end
        // seed adds, also right after a zeroing
        if (sync_event || sw_mod_rst) begin
            next_s.acc = seed_wr ? AVS_WRITEDATA[23:0] : 24'h0;
        end else if (seed_wr) begin
            next_s.acc = s.acc + AVS_WRITEDATA[23:0];
        end
        next_s.rdata = 32'h0;
        if (AVS_READ && !s.ack) begin
            unique case (AVS_ADDRESS)
                OFS_CTRL: next_s.rdata = {24'h0, s.order, s.frac_mode, 2'b00,
                                          s.pin_mask, s.sync_en};
                OFS_DIV: next_s.rdata = {20'h0, s.b_sel, s.a_sel, s.ratio};
                OFS_DEN: next_s.rdata = {8'h0, s.den};
                OFS_SEED: next_s.rdata = {8'h0, s.acc};
                OFS_RSTDLY: next_s.rdata = {16'h0, s.rst_dly};
                OFS_STATUS: next_s.rdata = {23'h0, (s.calc != CALC_IDLE) || s.dirty,
                                            s.shift_ok, s.stage2, s.incl, s.determ,
                                            s.seq != SEQ_IDLE && s.seq != SEQ_DONE};
                OFS_PHASE: next_s.rdata = s.phase;
                OFS_VCO_READ: next_s.rdata = {12'h0, s.rd_bias, s.rd_cap, s.rd_core};
                OFS_VCO_FORCE: next_s.rdata = {s.force_en, 11'h0, s.force_bias,
                                               s.force_cap, s.force_core};
                default: next_s.rdata = 32'h0;
            endcase
        end else if (rd_acc) begin
            next_s.rdata = s.rdata;
        end
        // event leaves on the next reference edge
        next_s.sync_pulse = sync_event;
        next_s.cal_start = sync_event;
        next_s.mod_rst = sw_mod_rst;
        // wait through cal, settle and reset delay
        unique case (s.seq)
            SEQ_IDLE: ;
            SEQ_CAL: begin
                if (CAL_DONE) begin
                    next_s.rd_core = CAL_CORE;
                    next_s.rd_cap = CAL_CAPCODE;
                    next_s.rd_bias = CAL_BIAS;
                    next_s.seq = SEQ_SETTLE;
                    next_s.cnt = SETTLE_CYCLES - 16'h0001;
                end
            end
            SEQ_SETTLE: begin
                if (s.cnt != 16'h0) begin
                    next_s.cnt = s.cnt - 16'h0001;
                end else if (s.frac_mode && s.rst_dly != 16'h0) begin
                    next_s.seq = SEQ_MODRST;
                    next_s.cnt = s.rst_dly - 16'h0001;
                end else begin
                    next_s.seq = SEQ_DONE;
                    next_s.determ = 1'b1;
                end
            end
            SEQ_MODRST: begin
                if (s.cnt != 16'h0) begin
                    next_s.cnt = s.cnt - 16'h0001;
                end else begin
                    next_s.seq = SEQ_DONE;
                    next_s.determ = 1'b1;
                end
            end
            SEQ_DONE: ;
            default: next_s.seq = SEQ_IDLE;
        endcase
        if (!next_s.sync_en) begin
            next_s.seq = SEQ_IDLE;
            next_s.determ = 1'b0;
        end
        // a new event restarts the sequence even mid-way
        if (sync_event) begin
            next_s.seq = SEQ_CAL;
            next_s.determ = 1'b0;
        end
        // degrees recomputed whenever an input moves
        div_start = 1'b0;
        div_dividend = {16'h0, s.acc};
        div_divisor = {16'h0, s.den};
        unique case (s.calc)
            CALC_IDLE: begin
                if (s.dirty && !div_busy) begin
                    div_start = 1'b1;
                    next_s.dirty = 1'b0;
                    next_s.calc = CALC_MOD;
                end
            end
            CALC_MOD: begin
                if (div_done) begin
                    // order zero or off-multiple first order gives no shift
                    next_s.shift_ok = (s.order != 3'h0)
                                      && (s.order != 3'h1 || div_rem == 40'h0);
                    div_start = 1'b1;
                    div_dividend = 40'({16'h0, s.acc} * FULL_TURN_DEG * {37'h0, s.incl});
                    div_divisor = 40'({16'h0, s.den} * {32'h0, s.ratio});
                    next_s.calc = CALC_PHASE;
                end
            end
            CALC_PHASE: begin
                if (div_done) begin
                    next_s.phase = div_quo[31:0];
                    next_s.calc = CALC_IDLE;
                end
            end
            default: next_s.calc = CALC_IDLE;
        endcase
        // a fresh change wins over the clear at job start
        if (next_s.acc != s.acc || next_s.den != s.den || next_s.ratio != s.ratio
            || next_s.incl != s.incl || next_s.order != s.order) begin
            next_s.dirty = 1'b1;
        end
    end

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s <= '0;
            s.pin_mask <= RST_PIN_MASK;
            s.ratio <= RST_RATIO;
            s.a_sel <= RST_SEL;
            s.b_sel <= RST_SEL;
            s.den <= RST_DEN;
            s.rst_dly <= RST_RSTDLY;
            s.incl <= 3'h1;
            s.stage2 <= 2'h2;
            s.seq <= SEQ_IDLE;
            s.calc <= CALC_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign AVS_WAITREQUEST     = (AVS_READ || AVS_WRITE) && !s.ack;
    assign AVS_READDATA        = s.rdata;
    assign SYNC_MODE           = s.sync_en;
    assign SYNC_PULSE          = s.sync_pulse;
    assign CAL_START           = s.cal_start;
    assign MOD_RESET           = s.mod_rst;
    assign PHASE_DETERMINISTIC = s.determ;
    assign INCLUDED_DIVIDE     = s.incl;
    assign STAGE_SECOND        = s.stage2;
    assign PHASE_OFFSET        = s.acc;
    // forced settings offered to later calibrations
    assign FORCE_EN            = s.force_en;
    assign FORCE_CORE          = s.force_core;
    assign FORCE_CAPCODE       = s.force_cap;
    assign FORCE_BIAS          = s.force_bias;

    sequence settle_over;
        (s.seq == SEQ_SETTLE) && (s.cnt == 16'h0);
    endsequence
    sequence delay_over;
        (s.seq == SEQ_MODRST) && (s.cnt == 16'h0);
    endsequence

    chk_pin_sync_edge: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        pin_event |=> (SYNC_PULSE && CAL_START) ##1 (!SYNC_PULSE || $past(sync_event)))
        else $error("pin edge did not give a sync pulse");
    chk_pin_mask_block: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        (s.pin_mask || !s.sync_en) && !sw_sync |=> !SYNC_PULSE)
        else $error("masked pin produced a sync");
    chk_sw_sync_edge: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        sw_sync |=> SYNC_PULSE && s.seq == SEQ_CAL && !PHASE_DETERMINISTIC)
        else $error("enable rising did not start sync");
    chk_init_write: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        wr_acc && AVS_ADDRESS == OFS_CTRL && AVS_WRITEDATA[CTRL_INIT] && !pin_event
        |=> !SYNC_PULSE)
        else $error("initial programming write gave a sync");
    chk_offset_zero: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        (sync_event || sw_mod_rst) && !seed_wr |=> PHASE_OFFSET == 24'h0)
        else $error("offset not zeroed by sync or reset");
    chk_seed_adds: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        seed_wr && !sync_event && !sw_mod_rst
        |=> PHASE_OFFSET == 24'($past(s.acc) + $past(AVS_WRITEDATA[23:0])))
        else $error("seed write did not accumulate");
    chk_incl_one: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        !s.sync_en || (s.a_sel != SEL_OUTPUT_DIVIDE_RATIO && s.b_sel != SEL_OUTPUT_DIVIDE_RATIO
                       && s.b_sel != SEL_CONV_REF) |=> INCLUDED_DIVIDE == 3'h1)
        else $error("included divide not one");
    chk_incl_six: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        s.sync_en && s.a_sel == SEL_OUTPUT_DIVIDE_RATIO && s.ratio == 8'h0C |=> INCLUDED_DIVIDE == 3'h6)
        else $error("included divide not six");
    chk_ratio_two: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        s.sync_en && s.b_sel == SEL_OUTPUT_DIVIDE_RATIO && s.ratio == 8'h02 |=> INCLUDED_DIVIDE == 3'h4)
        else $error("ratio two did not give four");
    chk_determ_wait: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        $rose(s.determ) |-> $past(s.seq == SEQ_SETTLE && s.cnt == 16'h0)
                            || $past(s.seq == SEQ_MODRST && s.cnt == 16'h0))
        else $error("deterministic flagged before waits ended");
    chk_settle_end: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        settle_over ##0 (!s.frac_mode || s.rst_dly == 16'h0) && next_s.sync_en && !sync_event
        |=> PHASE_DETERMINISTIC)
        else $error("settle end did not reach deterministic");
    chk_delay_end: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        delay_over ##0 next_s.sync_en && !sync_event |=> PHASE_DETERMINISTIC)
        else $error("reset delay end did not reach deterministic");
    chk_vco_readback: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        s.seq == SEQ_CAL && CAL_DONE && !sync_event
        |=> s.rd_core == $past(CAL_CORE) && s.rd_bias == $past(CAL_BIAS))
        else $error("calibration result not captured");
endmodule

`default_nettype wire

// [psa_cal_model.sv]
// Purpose: calibration engine stand-in on the far side of the sync block
// Assumes: start is a one-cycle pulse on clk
// Notes:   answer delay set by dly; codes stay fixed so readback is predictable
`default_nettype none
module psa_cal_model (
    input  wire logic       clk,
    input  wire logic       start,
    input  wire logic [7:0] dly,
    output logic            done,
    output logic      [2:0] core,
    output logic      [7:0] cap,
    output logic      [8:0] bias
);
    timeunit 1ns;
    timeprecision 1ns;
    int   cnt = -1;
    logic d   = 1'b0;
    always @(posedge clk) begin
        d <= (cnt == 0);
        if (start) cnt <= int'(dly);
        else if (cnt >= 0) cnt <= cnt - 1;
    end
    assign done = d;
    assign core = 3'h5;
    assign cap  = 8'hA6;
    assign bias = 9'h13B;
endmodule
`default_nettype wire

// [testbench.sv]
// Purpose: self-checking bench for the sync and phase adjust block
// Assumes: the slave answers in its own time; every wait is bounded
// Notes:   expected read values are queued by the driver and compared by a monitor
`default_nettype none
module testbench;
    import psa_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic REF_CLK = 0, RESET_N = 0, AVS_READ = 0, AVS_WRITE = 0, SYNC_PIN = 0, CAL_DONE;
    logic [5:0]  AVS_ADDRESS = 6'h00;
    logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, r, q[$];
    logic AVS_WAITREQUEST, SYNC_MODE, SYNC_PULSE, CAL_START, MOD_RESET, PHASE_DETERMINISTIC;
    logic FORCE_EN;
    logic [2:0]  INCLUDED_DIVIDE, CAL_CORE, FORCE_CORE;
    logic [1:0]  STAGE_SECOND;
    logic [23:0] PHASE_OFFSET;
    logic [7:0]  CAL_CAPCODE, FORCE_CAPCODE;
    logic [8:0]  CAL_BIAS, FORCE_BIAS;
    logic [11:0] dv[8] = '{12'h102, 12'h406, 12'h418, 12'h4C0, 12'h40C, 12'h410, 12'h506, 12'h906};
    logic [2:0]  ex[8] = '{3'h4, 3'h6, 3'h4, 3'h4, 3'h6, 3'h4, 3'h1, 3'h6};
    int n_errors = 0, checks_done = 0, n_sync = 0, n_mrst = 0, seed = 32'hc1812414, i;
    psa_top uut (.*);
    psa_cal_model cal (.clk(REF_CLK), .start(CAL_START), .dly(8'h28), .done(CAL_DONE),
                       .core(CAL_CORE), .cap(CAL_CAPCODE), .bias(CAL_BIAS));
    initial forever #50 REF_CLK = ~REF_CLK;
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task end_of_test;
        $display("checks=%0d errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // request held until waitrequest is sampled low, then released
    task bus(input logic [5:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= w;
        AVS_READ <= !w;
        do begin
            @(posedge REF_CLK);
            n++;
        end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
        if (n >= 50) begin
            n_errors++;
            end_of_test();
        end
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        @(posedge REF_CLK);
    endtask
    task rd(input logic [5:0] a, input logic [31:0] e);
        q.push_back(e);
        bus(a, 1'b0, 32'h0);
    endtask
    always @(posedge REF_CLK) begin
        if (AVS_READ && AVS_WAITREQUEST === 1'b0) chk(AVS_READDATA, q.pop_front());
        n_sync <= n_sync + int'(SYNC_PULSE === 1'b1 && CAL_START === 1'b1);
        n_mrst <= n_mrst + int'(MOD_RESET === 1'b1);
    end
    initial begin
        repeat (100000) @(posedge REF_CLK);
        n_errors++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge REF_CLK);
        RESET_N <= 1'b1;
        @(posedge REF_CLK);
        rd(OFS_CTRL, 32'h2);
        rd(OFS_DIV, 32'h502);
        bus(OFS_CTRL, 1'b1, 32'h5);
        for (i = 0; i < 8; i++) begin
            bus(OFS_DIV, 1'b1, {20'h0, dv[i]});
            repeat (2) @(posedge REF_CLK);
            chk(32'(INCLUDED_DIVIDE), 32'(ex[i]));
        end
        chk(n_sync, 0);
        $display("divide table done");
        bus(OFS_DEN, 1'b1, 32'hC);
        bus(OFS_DIV, 1'b1, 32'h410);
        bus(OFS_SEED, 1'b1, 32'h1);
        repeat (200) @(posedge REF_CLK);
        rd(OFS_PHASE, 32'h7);
        bus(OFS_CTRL, 1'b1, 32'h25);
        repeat (100) @(posedge REF_CLK);
        rd(OFS_STATUS, 32'h50);
        bus(OFS_CTRL, 1'b1, 32'h45);
        repeat (100) @(posedge REF_CLK);
        rd(OFS_STATUS, 32'hD0);
        r = $random(seed) & 32'hFFFF;
        bus(OFS_SEED, 1'b1, r);
        rd(OFS_SEED, r + 1);
        chk(32'(PHASE_OFFSET), r + 1);
        bus(OFS_RSTDLY, 1'b1, 32'h64);
        bus(OFS_CTRL, 1'b1, 32'h2);
        bus(OFS_CTRL, 1'b1, 32'h11);
        repeat (2) @(posedge REF_CLK);
        chk(n_sync, 1);
        chk(32'(SYNC_MODE), 1);
        chk(32'(PHASE_OFFSET), 0);
        repeat (600) @(posedge REF_CLK);
        chk(32'(PHASE_DETERMINISTIC), 0);
        for (i = 0; i < 1000 && PHASE_DETERMINISTIC !== 1'b1; i++) @(posedge REF_CLK);
        chk(32'(PHASE_DETERMINISTIC), 1);
        rd(OFS_VCO_READ, {12'h0, 9'h13B, 8'hA6, 3'h5});
        bus(OFS_VCO_FORCE, 1'b1, 32'h800A5A5D);
        chk({FORCE_EN, 11'h0, FORCE_BIAS, FORCE_CAPCODE, FORCE_CORE}, 32'h800A5A5D);
        $display("software sync done");
        bus(OFS_SEED, 1'b1, 32'h3);
        SYNC_PIN <= 1'b1;
        repeat (6) @(posedge REF_CLK);
        chk(n_sync, 2);
        chk(32'(PHASE_OFFSET), 0);
        SYNC_PIN <= 1'b0;
        bus(OFS_SEED, 1'b1, 32'h9);
        chk(32'(PHASE_OFFSET), 32'h9);
        bus(OFS_CTRL, 1'b1, 32'h9);
        repeat (2) @(posedge REF_CLK);
        chk(32'(PHASE_OFFSET), 0);
        chk(n_sync, 2);
        chk(n_mrst, 1);
        bus(OFS_CTRL, 1'b1, 32'h3);
        SYNC_PIN <= 1'b1;
        repeat (6) @(posedge REF_CLK);
        chk(n_sync, 2);
        $display("pin sync and reset done");
        SYNC_PIN <= 1'b0;
        RESET_N <= 1'b0;
        repeat (2) @(posedge REF_CLK);
        RESET_N <= 1'b1;
        @(posedge REF_CLK);
        chk(32'({SYNC_MODE, STAGE_SECOND, INCLUDED_DIVIDE}), 32'h11);
        rd(OFS_CTRL, 32'h2);
        $display("mid-run reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
